//--- pkg/seem_map.svh
`ifndef SEEM_MAP_SVH
`define SEEM_MAP_SVH

// register select codes on the command port
`define SEEM_SEL_MEAS_EN 4'h0
`define SEEM_SEL_QUES_EN 4'h1
`define SEEM_SEL_OPER_EN 4'h2
`define SEEM_SEL_TRIG_EN 4'h3
`define SEEM_SEL_ARM_EN 4'h4
`define SEEM_SEL_TIER_EN 4'h5
`define SEEM_SEL_TRIG_EV 4'h6
`define SEEM_SEL_ARM_EV 4'h7
`define SEEM_SEL_TIER_EV 4'h8
`define SEEM_SEL_TRIG_PTR 4'h9
`define SEEM_SEL_TRIG_NTR 4'ha
`define SEEM_SEL_ARM_PTR 4'hb
`define SEEM_SEL_ARM_NTR 4'hc
`define SEEM_SEL_TIER_PTR 4'hd
`define SEEM_SEL_TIER_NTR 4'he
`define SEEM_SEL_CLEAR_ALL 4'hf

// bit positions
`define SEEM_B_FIRST_SEQ 1
`define SEEM_B_TIER_ONE 1
`define SEEM_B_TIER_TWO 2
`define SEEM_B_ALWAYS_ZERO 15

// implemented bits of each register
`define SEEM_IMPL_MEAS 16'h5bff
`define SEEM_IMPL_QUES 16'h5b13
`define SEEM_IMPL_OPER 16'h0e61
`define SEEM_IMPL_TRIG 16'h0002
`define SEEM_IMPL_ARM 16'h0002
`define SEEM_IMPL_TIER 16'h0006

// reset values
`define SEEM_RST_ENABLE 16'h0000
`define SEEM_RST_PTR 16'hffff
`define SEEM_RST_NTR 16'h0000
`define SEEM_RST_EVENTS 16'h0000

`endif

//--- pkg/seem_pkg.sv
`default_nettype none
package seem_pkg;
  // command from the host controller
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] sel;
    logic [15:0] data;
  } seem_cmd_s;
  // answer to a query
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } seem_rsp_s;
  // summary bits toward the next register set
  typedef struct packed {
    logic meas;
    logic ques;
    logic oper;
    logic trig;
    logic arm;
    logic tier;
  } seem_summary_s;
  typedef struct packed {
    logic [15:0] value;
  } seem_mask_state_s;
  typedef struct packed {
    logic [15:0] prev;
    logic [15:0] events;
  } seem_layer_state_s;
  typedef struct packed {
    seem_rsp_s rsp;
    seem_summary_s summ;
  } seem_top_state_s;
endpackage
`default_nettype wire

//--- verilog/seem_mask_reg.sv
`include "seem_map.svh"
`default_nettype none
module seem_mask_reg
  import seem_pkg::*;
#(
  parameter logic [15:0] IMPL = 16'hffff,
  parameter logic [15:0] RST = 16'h0000
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // write strobe and value
  input wire logic wr_in,
  input wire logic [15:0] data_in,
  // current contents
  output logic [15:0] value_out
);
  seem_mask_state_s st;
  seem_mask_state_s next_st;

  // whole pattern loaded at once, unimplemented bits forced low
  always_comb begin
    next_st = st;
    if (wr_in) begin
      next_st.value = data_in & IMPL;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st.value <= RST & IMPL;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign value_out = st.value;

  a_unimpl_low: assert property (@(posedge clk_in) disable iff (!resetn_in) (st.value & ~IMPL) == 16'h0000)
    else $error("unimplemented mask bit set");
endmodule
`default_nettype wire

//--- verilog/seem_event_layer.sv
`include "seem_map.svh"
`default_nettype none
module seem_event_layer
  import seem_pkg::*;
#(
  parameter logic [15:0] IMPL = 16'h0002
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // condition and transition filters
  input wire logic [15:0] cond_in,
  input wire logic [15:0] ptr_in,
  input wire logic [15:0] ntr_in,
  // clear all latched events
  input wire logic clr_in,
  // latched events
  output logic [15:0] events_out
);
  seem_layer_state_s st;
  seem_layer_state_s next_st;
  logic [15:0] rise;
  logic [15:0] fall;

  // edges against last sampled condition, gated by the filters
  always_comb begin
    rise = cond_in & ~st.prev & ptr_in & IMPL;
    fall = ~cond_in & st.prev & ntr_in & IMPL;
    next_st.prev = cond_in;
    // set beats clear so an edge on the clearing cycle survives
    next_st.events = ((clr_in ? 16'h0000 : st.events) | rise | fall) & IMPL;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st.prev <= 16'h0000;
      st.events <= `SEEM_RST_EVENTS;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign events_out = st.events;

  a_rise_sets: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && (rise != 16'h0000) |=> (st.events & $past(rise)) == $past(rise))
    else $error("rising edge did not set event");
  a_fall_sets: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && (fall != 16'h0000) |=> (st.events & $past(fall)) == $past(fall))
    else $error("falling edge did not set event");
  a_latch_holds: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !clr_in |=> ($past(st.events) & ~st.events) == 16'h0000)
    else $error("latched event lost without clear");
  a_no_filter: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && !clr_in && (cond_in == st.prev) |=> st.events == $past(st.events))
    else $error("event set without transition");
endmodule
`default_nettype wire

//--- verilog/seem_top.sv
// Overview of operation
// - trigger layer entry/exit sets trigger bit one
// - arm layer entry/exit sets arm bit one
// - arm tier one transition sets tier bit one
// - arm tier two transition sets tier bit two
// - bit fifteen of events always zero
// - trigger, arm events only bit one
// - cleared enable bit masks event from summary
// - enabled set event sets next summary bit
// - enable written whole as one value
// - query returns current enable register contents
// - six separate enable registers exist
// - measurement enable bit layout as listed
// - questionable enable bit layout as listed
// - operation enable bit layout as listed
// - trigger, arm enables hold only bit one
// - tier enable holds bits one and two
// - rising means zero to one, filtered
`include "seem_map.svh"
`default_nettype none
module seem_top
  import seem_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // instrument layer conditions
  input wire logic trig_layer_in,
  input wire logic arm_layer_in,
  input wire logic arm_tier_one_in,
  input wire logic arm_tier_two_in,
  // latched events of the outer register sets
  input wire logic [15:0] meas_events_in,
  input wire logic [15:0] ques_events_in,
  input wire logic [15:0] oper_events_in,
  // host command port
  input wire seem_cmd_s cmd_in,
  output seem_rsp_s rsp_out,
  // summaries toward the next register set
  output seem_summary_s summary_out
);
  seem_top_state_s st;
  seem_top_state_s next_st;

  logic take;
  logic [15:0] wr_sel;
  logic clear_all;
  logic [15:0] meas_en;
  logic [15:0] ques_en;
  logic [15:0] oper_en;
  logic [15:0] trig_en;
  logic [15:0] arm_en;
  logic [15:0] tier_en;
  logic [15:0] trig_ptr;
  logic [15:0] trig_ntr;
  logic [15:0] arm_ptr;
  logic [15:0] arm_ntr;
  logic [15:0] tier_ptr;
  logic [15:0] tier_ntr;
  logic [15:0] trig_cond;
  logic [15:0] arm_cond;
  logic [15:0] tier_cond;
  logic [15:0] trig_ev;
  logic [15:0] arm_ev;
  logic [15:0] tier_ev;
  logic trig_clr;
  logic arm_clr;
  logic tier_clr;
  logic [15:0] rd_data;

  // one-hot write strobes; commands are ignored while frozen
  always_comb begin
    take = ce_in && cmd_in.valid;
    wr_sel = 16'h0000;
    if (take && cmd_in.write) begin
      wr_sel[cmd_in.sel] = 1'b1;
    end
    clear_all = wr_sel[`SEEM_SEL_CLEAR_ALL];
  end

  // six enable registers, one per event register
  seem_mask_reg #(.IMPL(`SEEM_IMPL_MEAS), .RST(`SEEM_RST_ENABLE)) u_meas_en (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_in(wr_sel[`SEEM_SEL_MEAS_EN]),
    .data_in(cmd_in.data),
    .value_out(meas_en)
  );
  seem_mask_reg #(.IMPL(`SEEM_IMPL_QUES), .RST(`SEEM_RST_ENABLE)) u_ques_en (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_in(wr_sel[`SEEM_SEL_QUES_EN]),
    .data_in(cmd_in.data),
    .value_out(ques_en)
  );
  seem_mask_reg #(.IMPL(`SEEM_IMPL_OPER), .RST(`SEEM_RST_ENABLE)) u_oper_en (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_in(wr_sel[`SEEM_SEL_OPER_EN]),
    .data_in(cmd_in.data),
    .value_out(oper_en)
  );
  seem_mask_reg #(.IMPL(`SEEM_IMPL_TRIG), .RST(`SEEM_RST_ENABLE)) u_trig_en (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_in(wr_sel[`SEEM_SEL_TRIG_EN]),
    .data_in(cmd_in.data),
    .value_out(trig_en)
  );
  seem_mask_reg #(.IMPL(`SEEM_IMPL_ARM), .RST(`SEEM_RST_ENABLE)) u_arm_en (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_in(wr_sel[`SEEM_SEL_ARM_EN]),
    .data_in(cmd_in.data),
    .value_out(arm_en)
  );
  seem_mask_reg #(.IMPL(`SEEM_IMPL_TIER), .RST(`SEEM_RST_ENABLE)) u_tier_en (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_in(wr_sel[`SEEM_SEL_TIER_EN]),
    .data_in(cmd_in.data),
    .value_out(tier_en)
  );

  // transition filters; rising enabled on every implemented bit after reset
  seem_mask_reg #(.IMPL(`SEEM_IMPL_TRIG), .RST(`SEEM_RST_PTR)) u_trig_ptr (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_in(wr_sel[`SEEM_SEL_TRIG_PTR]),
    .data_in(cmd_in.data),
    .value_out(trig_ptr)
  );
  seem_mask_reg #(.IMPL(`SEEM_IMPL_TRIG), .RST(`SEEM_RST_NTR)) u_trig_ntr (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_in(wr_sel[`SEEM_SEL_TRIG_NTR]),
    .data_in(cmd_in.data),
    .value_out(trig_ntr)
  );
  seem_mask_reg #(.IMPL(`SEEM_IMPL_ARM), .RST(`SEEM_RST_PTR)) u_arm_ptr (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_in(wr_sel[`SEEM_SEL_ARM_PTR]),
    .data_in(cmd_in.data),
    .value_out(arm_ptr)
  );
  seem_mask_reg #(.IMPL(`SEEM_IMPL_ARM), .RST(`SEEM_RST_NTR)) u_arm_ntr (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_in(wr_sel[`SEEM_SEL_ARM_NTR]),
    .data_in(cmd_in.data),
    .value_out(arm_ntr)
  );
  seem_mask_reg #(.IMPL(`SEEM_IMPL_TIER), .RST(`SEEM_RST_PTR)) u_tier_ptr (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_in(wr_sel[`SEEM_SEL_TIER_PTR]),
    .data_in(cmd_in.data),
    .value_out(tier_ptr)
  );
  seem_mask_reg #(.IMPL(`SEEM_IMPL_TIER), .RST(`SEEM_RST_NTR)) u_tier_ntr (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .wr_in(wr_sel[`SEEM_SEL_TIER_NTR]),
    .data_in(cmd_in.data),
    .value_out(tier_ntr)
  );

  // layer conditions placed at their event bit positions
  always_comb begin
    trig_cond = 16'h0000;
    arm_cond = 16'h0000;
    tier_cond = 16'h0000;
    trig_cond[`SEEM_B_FIRST_SEQ] = trig_layer_in;
    arm_cond[`SEEM_B_FIRST_SEQ] = arm_layer_in;
    tier_cond[`SEEM_B_TIER_ONE] = arm_tier_one_in;
    tier_cond[`SEEM_B_TIER_TWO] = arm_tier_two_in;
  end

  // a query of an event register reads and clears it
  always_comb begin
    trig_clr = clear_all || (take && !cmd_in.write && cmd_in.sel == `SEEM_SEL_TRIG_EV);
    arm_clr = clear_all || (take && !cmd_in.write && cmd_in.sel == `SEEM_SEL_ARM_EV);
    tier_clr = clear_all || (take && !cmd_in.write && cmd_in.sel == `SEEM_SEL_TIER_EV);
  end

  // three small event registers
  seem_event_layer #(.IMPL(`SEEM_IMPL_TRIG)) u_trig_ev (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .cond_in(trig_cond),
    .ptr_in(trig_ptr),
    .ntr_in(trig_ntr),
    .clr_in(trig_clr),
    .events_out(trig_ev)
  );
  seem_event_layer #(.IMPL(`SEEM_IMPL_ARM)) u_arm_ev (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .cond_in(arm_cond),
    .ptr_in(arm_ptr),
    .ntr_in(arm_ntr),
    .clr_in(arm_clr),
    .events_out(arm_ev)
  );
  seem_event_layer #(.IMPL(`SEEM_IMPL_TIER)) u_tier_ev (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .cond_in(tier_cond),
    .ptr_in(tier_ptr),
    .ntr_in(tier_ntr),
    .clr_in(tier_clr),
    .events_out(tier_ev)
  );

  // read mux; writes and the clear-all code read as zero
  always_comb begin
    unique case (cmd_in.sel)
      `SEEM_SEL_MEAS_EN: rd_data = meas_en;
      `SEEM_SEL_QUES_EN: rd_data = ques_en;
      `SEEM_SEL_OPER_EN: rd_data = oper_en;
      `SEEM_SEL_TRIG_EN: rd_data = trig_en;
      `SEEM_SEL_ARM_EN: rd_data = arm_en;
      `SEEM_SEL_TIER_EN: rd_data = tier_en;
      `SEEM_SEL_TRIG_EV: rd_data = trig_ev;
      `SEEM_SEL_ARM_EV: rd_data = arm_ev;
      `SEEM_SEL_TIER_EV: rd_data = tier_ev;
      `SEEM_SEL_TRIG_PTR: rd_data = trig_ptr;
      `SEEM_SEL_TRIG_NTR: rd_data = trig_ntr;
      `SEEM_SEL_ARM_PTR: rd_data = arm_ptr;
      `SEEM_SEL_ARM_NTR: rd_data = arm_ntr;
      `SEEM_SEL_TIER_PTR: rd_data = tier_ptr;
      `SEEM_SEL_TIER_NTR: rd_data = tier_ntr;
      `SEEM_SEL_CLEAR_ALL: rd_data = 16'h0000;
    endcase
  end

  // answer and summaries, registered so outputs come from flops
  always_comb begin
    next_st.rsp.valid = take && !cmd_in.write;
    next_st.rsp.data = (take && !cmd_in.write) ? rd_data : 16'h0000;
    // outer events arrive unfiltered, so mask off undefined bits too
    next_st.summ.meas = |(meas_events_in & meas_en);
    next_st.summ.ques = |(ques_events_in & ques_en);
    next_st.summ.oper = |(oper_events_in & oper_en);
    next_st.summ.trig = |(trig_ev & trig_en);
    next_st.summ.arm = |(arm_ev & arm_en);
    next_st.summ.tier = |(tier_ev & tier_en);
  end

  // frozen together with every other register while ce_in is low
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign rsp_out = st.rsp;
  assign summary_out = st.summ;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_write_loads: assert property (ce_in && cmd_in.valid && cmd_in.write && cmd_in.sel == `SEEM_SEL_MEAS_EN
    |=> meas_en == ($past(cmd_in.data) & `SEEM_IMPL_MEAS))
    else $error("measurement enable not loaded");
  a_query_returns: assert property (ce_in && cmd_in.valid && !cmd_in.write && cmd_in.sel == `SEEM_SEL_OPER_EN
    |=> rsp_out.valid && rsp_out.data == $past(oper_en))
    else $error("operation enable query wrong");
  a_mask_blocks: assert property (ce_in && (trig_ev & trig_en) == 16'h0000 |=> !summary_out.trig)
    else $error("masked trigger event reached summary");
  a_summary_sets: assert property (ce_in && (meas_events_in & meas_en) != 16'h0000 |=> summary_out.meas)
    else $error("enabled measurement event gave no summary");
  a_bit15_zero: assert property (!trig_ev[15] && !arm_ev[15] && !tier_ev[15] && !rsp_out.data[15])
    else $error("bit fifteen set");
  a_unused_zero: assert property (((trig_ev | arm_ev) & ~`SEEM_IMPL_TRIG) == 16'h0000)
    else $error("unused trigger or arm event bit set");
  a_tier_rise: assert property (ce_in && !arm_tier_two_in
    ##1 ce_in && arm_tier_two_in && tier_ptr[`SEEM_B_TIER_TWO] |=> tier_ev[`SEEM_B_TIER_TWO])
    else $error("tier two rising not latched");
  a_trig_rise: assert property (ce_in && !trig_layer_in ##1 ce_in && trig_layer_in && trig_ptr[1]
    |=> trig_ev[`SEEM_B_FIRST_SEQ])
    else $error("trigger layer entry not latched");
  a_frozen_hold: assert property (!ce_in |=> $stable(rsp_out) && $stable(summary_out))
    else $error("state moved while frozen");
  // trigger exit, arm entry and tier one entry, one check per source
  a_trig_fall: assert property (ce_in && trig_layer_in
    ##1 ce_in && !trig_layer_in && trig_ntr[`SEEM_B_FIRST_SEQ] |=> trig_ev[`SEEM_B_FIRST_SEQ])
    else $error("trigger layer exit not latched");
  a_arm_rise: assert property (ce_in && !arm_layer_in
    ##1 ce_in && arm_layer_in && arm_ptr[`SEEM_B_FIRST_SEQ] |=> arm_ev[`SEEM_B_FIRST_SEQ])
    else $error("arm layer entry not latched");
  a_tier_one_rise: assert property (ce_in && !arm_tier_one_in
    ##1 ce_in && arm_tier_one_in && tier_ptr[`SEEM_B_TIER_ONE] |=> tier_ev[`SEEM_B_TIER_ONE])
    else $error("tier one entry not latched");
  a_clear_empties: assert property (clear_all && $past(resetn_in) && $past(ce_in) && $stable(trig_cond)
    && $stable(arm_cond) && $stable(tier_cond) |=> (trig_ev | arm_ev | tier_ev) == 16'h0000)
    else $error("clear all left an event set");
  a_rsp_quiet: assert property (ce_in && !(cmd_in.valid && !cmd_in.write)
    |=> !rsp_out.valid && rsp_out.data == 16'h0000)
    else $error("answer without a query");
  a_ques_masked: assert property (ce_in && (ques_events_in & ques_en) == 16'h0000
    |=> !summary_out.ques)
    else $error("masked questionable event reached summary");
  a_oper_summary: assert property (ce_in && (oper_events_in & oper_en) != 16'h0000
    |=> summary_out.oper)
    else $error("enabled operation event gave no summary");
  a_arm_summary: assert property (ce_in && (arm_ev & arm_en) != 16'h0000
    |=> summary_out.arm)
    else $error("enabled arm event gave no summary");

  c_trig_summary: cover property (ce_in ##1 $rose(summary_out.trig));
  c_query_answer: cover property (ce_in && cmd_in.valid && !cmd_in.write ##1 rsp_out.valid);
  c_write_all: cover property (ce_in && cmd_in.valid && cmd_in.write && cmd_in.data == 16'hffff);
  c_tier_fall: cover property (ce_in && $fell(arm_tier_one_in) && tier_ntr[1]);
  c_clear_all: cover property (clear_all ##1 (trig_ev | arm_ev | tier_ev) == 16'h0000);
endmodule
`default_nettype wire

//--- sim/seem_host_model.sv
`include "seem_map.svh"
`default_nettype none
module seem_host_model
  import seem_pkg::*;
(
  // clock
  input wire logic clk_in,
  // command out, answer back
  output var seem_cmd_s cmd_out,
  input wire seem_rsp_s rsp_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle port from time zero
  initial begin
    cmd_out = '0;
  end

  // held across the taking edge; idle lines then scrambled so stale values never pass
  task automatic send(input logic wr, input logic [3:0] sel, input logic [15:0] data);
    @(negedge clk_in);
    cmd_out <= '{valid: 1'b1, write: wr, sel: sel, data: data};
    @(negedge clk_in);
    cmd_out <= '{valid: 1'b0, write: ~wr, sel: ~sel, data: ~data};
  endtask

  // whole pattern as one value, no bitwise updates
  task automatic write_reg(input logic [3:0] sel, input logic [15:0] value);
    send(1'b1, sel, value);
  endtask

  // answer stands from the taking edge for one cycle only; send returns mid-cycle inside it
  task automatic read_reg(input logic [3:0] sel, output seem_rsp_s rsp);
    send(1'b0, sel, 16'h0000);
    rsp = rsp_in;
  endtask
endmodule
`default_nettype wire

//--- sim/seem_top_test.sv
`include "seem_map.svh"
`default_nettype none
`define SEEM_TB_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module seem_top_test
  import seem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] layer_cond = 4'h0;
  logic [15:0] outer_ev [3] = '{16'h0000, 16'h0000, 16'h0000};
  seem_cmd_s cmd;
  seem_rsp_s rsp;
  seem_summary_s summ;
  int bad_count = 0;
  int total_checks = 0;
  localparam logic [15:0] IMPL_TAB [6] = '{`SEEM_IMPL_MEAS, `SEEM_IMPL_QUES, `SEEM_IMPL_OPER,
    `SEEM_IMPL_TRIG, `SEEM_IMPL_ARM, `SEEM_IMPL_TIER};

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  seem_top DUT (
    .clk_in(clk),
    .resetn_in(resetn),
    .ce_in(ce),
    .trig_layer_in(layer_cond[0]),
    .arm_layer_in(layer_cond[1]),
    .arm_tier_one_in(layer_cond[2]),
    .arm_tier_two_in(layer_cond[3]),
    .meas_events_in(outer_ev[0]),
    .ques_events_in(outer_ev[1]),
    .oper_events_in(outer_ev[2]),
    .cmd_in(cmd),
    .rsp_out(rsp),
    .summary_out(summ)
  );

  seem_host_model host (
    .clk_in(clk),
    .cmd_out(cmd),
    .rsp_in(rsp)
  );

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // every read must answer, with the expected word
  task automatic read_expect(input logic [3:0] sel, input logic [15:0] exp);
    seem_rsp_s r;
    host.read_reg(sel, r);
    `SEEM_TB_EQ(r.valid, 1'b1)
    `SEEM_TB_EQ(r.data, exp)
  endtask

  // everything but the rising filters cleared after reset
  task automatic check_reset();
    logic [15:0] want;
    `SEEM_TB_EQ(summ, 6'h00)
    // rising filters come up fully enabled, everything else empty
    for (int s = 0; s < 16; s++) begin
      case (s[3:0])
        `SEEM_SEL_TRIG_PTR: want = `SEEM_IMPL_TRIG;
        `SEEM_SEL_ARM_PTR: want = `SEEM_IMPL_ARM;
        `SEEM_SEL_TIER_PTR: want = `SEEM_IMPL_TIER;
        default: want = `SEEM_RST_ENABLE;
      endcase
      read_expect(s[3:0], want);
    end
  endtask

  // each enable alone, full pattern, dropped bits, frozen clock enable
  task automatic check_enables();
    for (int i = 0; i < 6; i++) begin
      host.write_reg(i[3:0], 16'hffff);
      for (int j = 0; j < 6; j++) begin
        read_expect(j[3:0], (i == j) ? IMPL_TAB[j] : 16'h0000);
      end
      host.write_reg(i[3:0], 16'h0000);
      read_expect(i[3:0], 16'h0000);
    end
    host.write_reg(`SEEM_SEL_MEAS_EN, 16'h0220);
    read_expect(`SEEM_SEL_MEAS_EN, 16'h0220);
    host.write_reg(`SEEM_SEL_MEAS_EN, 16'h0000);
    ce = 1'b0;
    host.write_reg(`SEEM_SEL_OPER_EN, 16'hffff);
    ce = 1'b1;
    read_expect(`SEEM_SEL_OPER_EN, 16'h0000);
  endtask

  // outer sets: only the unmasked bit reaches the summary
  task automatic check_outer();
    outer_ev = '{16'hffff, 16'hffff, 16'hffff};
    idle(3);
    `SEEM_TB_EQ(summ[5:3], 3'b000)
    for (int k = 0; k < 3; k++) begin
      host.write_reg(k[3:0], 16'h0800);
      idle(3);
      `SEEM_TB_EQ(summ[5:3], 3'b100 >> k)
      outer_ev[k] = 16'hf7ff;
      idle(3);
      `SEEM_TB_EQ(summ[5:3], 3'b000)
      outer_ev[k] = 16'hffff;
      host.write_reg(k[3:0], 16'h0000);
    end
    outer_ev = '{16'h0000, 16'h0000, 16'h0000};
  endtask

  // one layer: rising and falling filters, latching, masking of its summary
  task automatic check_layer(input int idx, input logic [3:0] ev_sel, input logic [3:0] ptr_sel,
    input logic [3:0] ntr_sel, input logic [3:0] en_sel, input logic [15:0] w, input int sbit);
    host.write_reg(en_sel, w);
    layer_cond[idx] = 1'b1;
    idle(3);
    `SEEM_TB_EQ(summ[sbit], 1'b1)
    layer_cond[idx] = 1'b0;
    idle(3);
    `SEEM_TB_EQ(summ[sbit], 1'b1)
    read_expect(ev_sel, w);
    read_expect(ev_sel, 16'h0000);
    `SEEM_TB_EQ(summ[sbit], 1'b0)
    host.write_reg(ptr_sel, 16'h0000);
    host.write_reg(ntr_sel, w);
    layer_cond[idx] = 1'b1;
    idle(3);
    read_expect(ev_sel, 16'h0000);
    layer_cond[idx] = 1'b0;
    idle(3);
    read_expect(ev_sel, w);
    // masked: latched event must stay out of the summary
    host.write_reg(en_sel, 16'h0000);
    host.write_reg(ptr_sel, 16'hffff);
    host.write_reg(ntr_sel, 16'h0000);
    layer_cond[idx] = 1'b1;
    idle(3);
    `SEEM_TB_EQ(summ[sbit], 1'b0)
    layer_cond[idx] = 1'b0;
    read_expect(ev_sel, w);
  endtask

  // clear-all empties the arm and tier event sets; a write to an event register changes nothing
  task automatic check_clear();
    host.write_reg(`SEEM_SEL_ARM_EN, 16'hffff);
    host.write_reg(`SEEM_SEL_TIER_EN, 16'hffff);
    layer_cond = 4'hf;
    idle(3);
    `SEEM_TB_EQ(summ[1:0], 2'b11)
    host.write_reg(`SEEM_SEL_TRIG_EV, 16'h0000);
    read_expect(`SEEM_SEL_TRIG_EV, `SEEM_IMPL_TRIG);
    host.write_reg(`SEEM_SEL_CLEAR_ALL, 16'h0000);
    read_expect(`SEEM_SEL_ARM_EV, 16'h0000);
    read_expect(`SEEM_SEL_TIER_EV, 16'h0000);
    `SEEM_TB_EQ(summ[1:0], 2'b00)
    layer_cond = 4'h0;
    host.write_reg(`SEEM_SEL_ARM_EN, 16'h0000);
    host.write_reg(`SEEM_SEL_TIER_EN, 16'h0000);
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // main sequence, reset held for 8 cycles
  initial begin
    idle(8);
    resetn = 1'b1;
    check_reset();
    check_enables();
    check_outer();
    check_layer(0, `SEEM_SEL_TRIG_EV, `SEEM_SEL_TRIG_PTR, `SEEM_SEL_TRIG_NTR, `SEEM_SEL_TRIG_EN, 16'h0002, 2);
    check_layer(1, `SEEM_SEL_ARM_EV, `SEEM_SEL_ARM_PTR, `SEEM_SEL_ARM_NTR, `SEEM_SEL_ARM_EN, 16'h0002, 1);
    check_layer(2, `SEEM_SEL_TIER_EV, `SEEM_SEL_TIER_PTR, `SEEM_SEL_TIER_NTR, `SEEM_SEL_TIER_EN, 16'h0002, 0);
    check_layer(3, `SEEM_SEL_TIER_EV, `SEEM_SEL_TIER_PTR, `SEEM_SEL_TIER_NTR, `SEEM_SEL_TIER_EN, 16'h0004, 0);
    check_clear();
    give_verdict();
  end

  // hang guard; the run needs far fewer cycles
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
